// *** hcd_cfg_regs.sv ***
/*
  Hub configuration register bank: controller current budget, power-on
  delay, language code, and three custom text descriptors stored as
  little-endian 16-bit characters, with a character stream for the
  descriptor engine and per-port power-good timing.
  Assumes the configuration loader drives a byte-wide port synchronous to
  sys_clk_in and the descriptor engine honours valid/ready.
*/
// Notes on behaviour
// - Bus-powered current counts 2 mA steps.
// - Current excludes compound device attached peripheral.
// - Bus-powered current resets to 50.
// - Power-on delay counts 2 ms units.
// - Language high byte is upper eight bits.
// - Language low byte is lower eight bits.
// - Text lengths above 31 are refused.
// - Text areas 16h-53h, 54h-91h, 92h-CFh.
// - Areas hold little-endian 16-bit characters.
// - Low byte at lower address.
// - Characters are contiguous from area start.
`timescale 1ns/10ps
module hcd_cfg_regs #(
  parameter int PORTS       = 4,
  parameter int UNIT_CYCLES = hcd_pkg::PWR_UNIT_CYCLES
) (
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             cfg_wr_in,
  input  wire logic             cfg_rd_in,
  input  wire logic [7:0]       cfg_addr_in,
  input  wire logic [7:0]       cfg_wdata_in,
  output logic      [7:0]       cfg_rdata_out,
  output logic                  cfg_rvalid_out,
  output logic                  cfg_wr_refused_out,
  input  wire logic             desc_start_in,
  input  wire logic [1:0]       desc_sel_in,
  input  wire logic             desc_ready_in,
  output logic      [15:0]      desc_char_out,
  output logic                  desc_valid_out,
  output logic                  desc_last_out,
  output logic                  desc_busy_out,
  output logic      [15:0]      language_code_out,
  output logic      [8:0]       controller_current_ma_out,
  output logic      [7:0]       port_power_good_delay_out,
  input  wire logic [PORTS-1:0] port_power_start_in,
  input  wire logic [PORTS-1:0] port_power_stop_in,
  output logic      [PORTS-1:0] port_power_good_out
);
  typedef enum logic [0:0] {
    HCD_IDLE,
    HCD_SEND
  } hcd_state_type;

  typedef struct packed {
    logic [7:0]                               cur_bp;
    logic [7:0]                               pwr_dly;
    logic [7:0]                               lang_hi;
    logic [7:0]                               lang_lo;
    logic [2:0][7:0]                          len;
    logic [hcd_pkg::TEXT_BYTES-1:0][7:0]      text;
    logic [7:0]                               rdata;
    logic                                     rvalid;
    logic                                     refused;
    hcd_state_type                            state;
    logic [1:0]                               sel;
    logic [4:0]                               idx;
    logic [4:0]                               cnt;
    logic [15:0]                              chr;
    logic                                     valid;
    logic                                     last;
    logic [15:0]                              lang;
    logic [8:0]                               cur_ma;
  } hcd_regs_type;

  hcd_regs_type st_r;
  hcd_regs_type st_nxt;

  if (PORTS < 1 || PORTS > 8) begin : g_chk
    $error("hcd_cfg_regs: PORTS must lie between 1 and 8");
  end

  // Offset of an address inside the shared text store
  function automatic logic [7:0] text_off(input logic [7:0] addr);
    text_off = addr - hcd_pkg::ADDR_MFR_TEXT;
  endfunction

  function automatic logic [7:0] area_base(input logic [1:0] sel);
    if (sel == hcd_pkg::SEL_PRD) begin
      area_base = text_off(hcd_pkg::ADDR_PRD_TEXT);
    end else if (sel == hcd_pkg::SEL_SER) begin
      area_base = text_off(hcd_pkg::ADDR_SER_TEXT);
    end else begin
      area_base = text_off(hcd_pkg::ADDR_MFR_TEXT);
    end
  endfunction

  // Low byte sits at the lower address, characters back to back
  function automatic logic [15:0] char_at(
    input logic [hcd_pkg::TEXT_BYTES-1:0][7:0] text,
    input logic [1:0]                          sel,
    input logic [4:0]                          idx
  );
    logic [7:0] lo;
    lo = area_base(sel) + {2'h0, idx, 1'b0};
    char_at = {text[lo + 8'h01], text[lo]};
  endfunction

  function automatic logic [1:0] len_slot(input logic [7:0] addr);
    len_slot = 2'(addr - hcd_pkg::ADDR_MFR_LEN);
  endfunction

  always_comb begin
    logic is_len;
    logic is_text;
    logic [1:0] slot;
    is_len  = 1'b0;
    is_text = 1'b0;
    slot    = 2'h0;
    st_nxt  = st_r;
    st_nxt.rvalid  = 1'b0;
    st_nxt.refused = 1'b0;

    if (cfg_addr_in >= hcd_pkg::ADDR_MFR_LEN &&
        cfg_addr_in <= hcd_pkg::ADDR_SER_LEN) begin
      is_len = 1'b1;
      slot   = len_slot(cfg_addr_in);
    end else if (cfg_addr_in >= hcd_pkg::ADDR_MFR_TEXT &&
                 cfg_addr_in <= hcd_pkg::ADDR_TEXT_END) begin
      is_text = 1'b1;
    end

    if (cfg_wr_in) begin
      if (cfg_addr_in == hcd_pkg::ADDR_CUR_BP) begin
        st_nxt.cur_bp = cfg_wdata_in;
      end else if (cfg_addr_in == hcd_pkg::ADDR_PWR_DLY) begin
        st_nxt.pwr_dly = cfg_wdata_in;
      end else if (cfg_addr_in == hcd_pkg::ADDR_LANG_HI) begin
        st_nxt.lang_hi = cfg_wdata_in;
      end else if (cfg_addr_in == hcd_pkg::ADDR_LANG_LO) begin
        st_nxt.lang_lo = cfg_wdata_in;
      end else if (is_len) begin
        // Oversized length keeps the old value
        if (cfg_wdata_in <= hcd_pkg::MAX_CHARS) begin
          st_nxt.len[slot] = cfg_wdata_in;
        end else begin
          st_nxt.refused = 1'b1;
        end
      end else if (is_text) begin
        // Bytes stored as given; no swapping is done here
        st_nxt.text[text_off(cfg_addr_in)] = cfg_wdata_in;
      end else begin
        st_nxt.refused = 1'b1;
      end
    end

    if (cfg_rd_in) begin
      st_nxt.rvalid = 1'b1;
      if (cfg_addr_in == hcd_pkg::ADDR_CUR_BP) begin
        st_nxt.rdata = st_r.cur_bp;
      end else if (cfg_addr_in == hcd_pkg::ADDR_PWR_DLY) begin
        st_nxt.rdata = st_r.pwr_dly;
      end else if (cfg_addr_in == hcd_pkg::ADDR_LANG_HI) begin
        st_nxt.rdata = st_r.lang_hi;
      end else if (cfg_addr_in == hcd_pkg::ADDR_LANG_LO) begin
        st_nxt.rdata = st_r.lang_lo;
      end else if (is_len) begin
        st_nxt.rdata = st_r.len[slot];
      end else if (is_text) begin
        st_nxt.rdata = st_r.text[text_off(cfg_addr_in)];
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end

    // Derived outputs follow the registers one cycle later
    st_nxt.lang   = {st_r.lang_hi, st_r.lang_lo};
    // Silicon plus board only; attached peripheral is not counted
    st_nxt.cur_ma = {st_r.cur_bp, 1'b0};

    case (st_r.state)
      HCD_IDLE: begin
        st_nxt.valid = 1'b0;
        st_nxt.last  = 1'b0;
        if (desc_start_in && desc_sel_in != 2'h3) begin
          st_nxt.state = HCD_SEND;
          st_nxt.sel   = desc_sel_in;
          st_nxt.idx   = 5'h00;
          st_nxt.cnt   = st_r.len[desc_sel_in][4:0];
        end
      end
      HCD_SEND: begin
        if (!st_r.valid || desc_ready_in) begin
          if (st_r.idx < st_r.cnt) begin
            st_nxt.chr   = char_at(st_r.text, st_r.sel, st_r.idx);
            st_nxt.valid = 1'b1;
            st_nxt.last  = (st_r.idx == st_r.cnt - 5'h01);
            st_nxt.idx   = st_r.idx + 5'h01;
          end else begin
            // Bytes past the count are never sent
            st_nxt.valid = 1'b0;
            st_nxt.last  = 1'b0;
            st_nxt.state = HCD_IDLE;
          end
        end
      end
      default: begin
        st_nxt.state = HCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_r         <= '0;
      st_r.cur_bp  <= hcd_pkg::RST_CUR_BP;
      st_r.pwr_dly <= hcd_pkg::RST_PWR_DLY;
      st_r.lang_hi <= hcd_pkg::RST_LANG_HI;
      st_r.lang_lo <= hcd_pkg::RST_LANG_LO;
      st_r.len     <= {3{hcd_pkg::RST_LEN}};
      st_r.text    <= {hcd_pkg::TEXT_BYTES{hcd_pkg::RST_TEXT}};
      st_r.state   <= HCD_IDLE;
      st_r.lang    <= {hcd_pkg::RST_LANG_HI, hcd_pkg::RST_LANG_LO};
      st_r.cur_ma  <= {hcd_pkg::RST_CUR_BP, 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  hcd_pwr_timer #(
    .PORTS       (PORTS),
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .sys_clk_in     (sys_clk_in),
    .sys_rst_in     (sys_rst_in),
    .start_in       (port_power_start_in),
    .stop_in        (port_power_stop_in),
    .delay_units_in (st_r.pwr_dly),
    .good_out       (port_power_good_out)
  );

  assign cfg_rdata_out             = st_r.rdata;
  assign cfg_rvalid_out            = st_r.rvalid;
  assign cfg_wr_refused_out        = st_r.refused;
  assign desc_char_out             = st_r.chr;
  assign desc_valid_out            = st_r.valid;
  assign desc_last_out             = st_r.last;
  assign desc_busy_out             = (st_r.state == HCD_SEND);
  assign language_code_out         = st_r.lang;
  assign controller_current_ma_out = st_r.cur_ma;
  assign port_power_good_delay_out = st_r.pwr_dly;
endmodule

// *** hcd_pkg.sv ***
/*
  Shared constants for the hub configuration and descriptor register bank:
  byte offsets, string area layout, reset values and timing figures.
  Assumes a single 50 MHz system clock.
*/
package hcd_pkg;
  localparam logic [7:0] ADDR_CUR_BP   = 8'h0f;
  localparam logic [7:0] ADDR_PWR_DLY  = 8'h10;
  localparam logic [7:0] ADDR_LANG_HI  = 8'h11;
  localparam logic [7:0] ADDR_LANG_LO  = 8'h12;
  localparam logic [7:0] ADDR_MFR_LEN  = 8'h13;
  localparam logic [7:0] ADDR_PRD_LEN  = 8'h14;
  localparam logic [7:0] ADDR_SER_LEN  = 8'h15;
  localparam logic [7:0] ADDR_MFR_TEXT = 8'h16;
  localparam logic [7:0] ADDR_PRD_TEXT = 8'h54;
  localparam logic [7:0] ADDR_SER_TEXT = 8'h92;
  localparam logic [7:0] ADDR_TEXT_END = 8'hcf;

  localparam int         AREA_BYTES    = 62;
  localparam int         TEXT_BYTES    = 186;
  localparam logic [7:0] MAX_CHARS     = 8'h1f;

  localparam logic [7:0] RST_CUR_BP    = 8'h32;
  localparam logic [7:0] RST_PWR_DLY   = 8'h00;
  localparam logic [7:0] RST_LANG_HI   = 8'h00;
  localparam logic [7:0] RST_LANG_LO   = 8'h00;
  localparam logic [7:0] RST_LEN       = 8'h00;
  localparam logic [7:0] RST_TEXT      = 8'h00;

  localparam int CUR_STEP_MA   = 2;
  localparam int PWR_UNIT_MS   = 2;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PWR_UNIT_CYCLES = (PWR_UNIT_MS * 1000000) / CLK_PERIOD_NS;

  localparam logic [1:0] SEL_MFR = 2'h0;
  localparam logic [1:0] SEL_PRD = 2'h1;
  localparam logic [1:0] SEL_SER = 2'h2;
endpackage

// *** hcd_pwr_timer.sv ***
/*
  Per-port power-good timer. A start pulse on a port arms a countdown of
  delay units; power good rises when the countdown ends.
  Assumes start pulses and the delay value are synchronous to sys_clk_in.
*/
`timescale 1ns/10ps
module hcd_pwr_timer #(
  parameter int PORTS       = 4,
  parameter int UNIT_CYCLES = hcd_pkg::PWR_UNIT_CYCLES
) (
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [PORTS-1:0] start_in,
  input  wire logic [PORTS-1:0] stop_in,
  input  wire logic [7:0]       delay_units_in,
  output logic      [PORTS-1:0] good_out
);
  localparam int TW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

  typedef struct packed {
    logic [PORTS-1:0]         run;
    logic [PORTS-1:0]         good;
    logic [PORTS-1:0][TW-1:0] tick;
    logic [PORTS-1:0][7:0]    units;
  } hcd_tmr_type;

  hcd_tmr_type st_r;
  hcd_tmr_type st_nxt;

  if (UNIT_CYCLES < 1 || PORTS < 1) begin : g_chk
    $error("hcd_pwr_timer: unit cycles and ports must be positive");
  end

  always_comb begin
    st_nxt = st_r;
    for (int p = 0; p < PORTS; p++) begin
      if (stop_in[p]) begin
        st_nxt.run[p]  = 1'b0;
        st_nxt.good[p] = 1'b0;
      end else if (start_in[p]) begin
        // Zero delay means power is good on the next edge
        st_nxt.run[p]   = (delay_units_in != 8'h00);
        st_nxt.good[p]  = (delay_units_in == 8'h00);
        st_nxt.units[p] = delay_units_in;
        st_nxt.tick[p]  = '0;
      end else if (st_r.run[p]) begin
        if (st_r.tick[p] == TW'(UNIT_CYCLES - 1)) begin
          st_nxt.tick[p]  = '0;
          st_nxt.units[p] = st_r.units[p] - 8'h01;
          if (st_r.units[p] == 8'h01) begin
            st_nxt.run[p]  = 1'b0;
            st_nxt.good[p] = 1'b1;
          end
        end else begin
          st_nxt.tick[p] = st_r.tick[p] + TW'(1);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign good_out = st_r.good;
endmodule

// *** hcd_cfg_regs_chk.sv ***
/* Port assertions for the hub configuration bank.
   Assumes it is bound to hcd_cfg_regs. */
`timescale 1ns/10ps
module hcd_chk #(
  parameter int PORTS = 4
) (
  input wire logic             sys_clk_in,
  input wire logic             sys_rst_in,
  input wire logic             cfg_wr_in,
  input wire logic             cfg_rd_in,
  input wire logic [7:0]       cfg_addr_in,
  input wire logic [7:0]       cfg_wdata_in,
  input wire logic [7:0]       cfg_rdata_out,
  input wire logic             cfg_rvalid_out,
  input wire logic             cfg_wr_refused_out,
  input wire logic             desc_ready_in,
  input wire logic             desc_valid_out,
  input wire logic             desc_last_out,
  input wire logic             desc_busy_out,
  input wire logic [15:0]      language_code_out,
  input wire logic [8:0]       controller_current_ma_out,
  input wire logic [7:0]       port_power_good_delay_out,
  input wire logic [PORTS-1:0] port_power_start_in,
  input wire logic [PORTS-1:0] port_power_stop_in,
  input wire logic [PORTS-1:0] port_power_good_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_wr(logic [7:0] ad);
    cfg_wr_in && cfg_addr_in == ad;
  endsequence
  sequence s_fin;
    desc_valid_out && desc_ready_in && desc_last_out;
  endsequence
  // Derived outputs lag the register by one cycle
  property p_cur;
    s_wr(hcd_pkg::ADDR_CUR_BP) |=> ##1
      controller_current_ma_out == {$past(cfg_wdata_in, 2), 1'b0};
  endproperty
  a_cur: assert property (p_cur) else $error("bad current");
  property p_rst;
    $fell(sys_rst_in) |-> controller_current_ma_out == 9'h064;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_lhi;
    s_wr(hcd_pkg::ADDR_LANG_HI) |=> ##1
      language_code_out[15:8] == $past(cfg_wdata_in, 2);
  endproperty
  a_lhi: assert property (p_lhi) else $error("bad lang high");
  property p_llo;
    s_wr(hcd_pkg::ADDR_LANG_LO) |=> ##1
      language_code_out[7:0] == $past(cfg_wdata_in, 2);
  endproperty
  a_llo: assert property (p_llo) else $error("bad lang low");
  property p_ref;
    cfg_wr_in && cfg_addr_in inside {[8'h13:8'h15]} |=>
      cfg_wr_refused_out == ($past(cfg_wdata_in) > hcd_pkg::MAX_CHARS);
  endproperty
  a_ref: assert property (p_ref) else $error("bad length refusal");
  property p_rd0;
    cfg_rd_in && cfg_addr_in > hcd_pkg::ADDR_TEXT_END |=>
      cfg_rvalid_out && cfg_rdata_out == 8'h00;
  endproperty
  a_rd0: assert property (p_rd0) else $error("bad unmapped read");
  property p_pwr;
    port_power_stop_in[0] ||
      port_power_start_in[0] && port_power_good_delay_out != 8'h00
      |=> !port_power_good_out[0];
  endproperty
  a_pwr: assert property (p_pwr) else $error("early power good");
  property p_fin;
    s_fin |=> !desc_valid_out ##1 !desc_busy_out;
  endproperty
  a_fin: assert property (p_fin) else $error("stream overrun");
endmodule
bind hcd_cfg_regs hcd_chk #(.PORTS(PORTS)) u_chk (
  .sys_clk_in, .sys_rst_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in,
  .cfg_wdata_in, .cfg_rdata_out, .cfg_rvalid_out, .cfg_wr_refused_out,
  .desc_ready_in, .desc_valid_out, .desc_last_out, .desc_busy_out,
  .language_code_out, .controller_current_ma_out,
  .port_power_good_delay_out, .port_power_start_in, .port_power_stop_in,
  .port_power_good_out);

// *** hcd_loader_model.sv ***
/* Configuration loader model: one byte read or write per call.
   Assumes the bank answers one cycle after each strobe. */
`timescale 1ns/10ps
module hcd_loader_model (
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  input  wire logic       refused_in,
  output logic            wr_out = 1'b0,
  output logic            rd_out = 1'b0,
  output logic      [7:0] addr_out = 8'h00,
  output logic      [7:0] wdata_out = 8'h00
);
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q, output logic flag);
    @(posedge sys_clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = w;
    rd_out = !w;
    @(posedge sys_clk_in);
    #1;
    wr_out = 1'b0;
    rd_out = 1'b0;
    // Released bus must not look like a repeat
    addr_out = ~a;
    wdata_out = ~d;
    q = rdata_in;
    flag = w ? refused_in : rvalid_in;
  endtask
endmodule

// *** hcd_cfg_regs_tb_top.sv ***
/* Self-checking bench for the hub configuration bank.
   Assumes the loader model and the bound checker. */
`timescale 1ns/10ps
module hcd_cfg_regs_tb_top;
  logic        sys_clk_in = 1'b0, sys_rst_in = 1'b1;
  logic        cfg_wr_in, cfg_rd_in, cfg_rvalid_out, cfg_wr_refused_out;
  logic [7:0]  cfg_addr_in, cfg_wdata_in, cfg_rdata_out, q;
  logic        desc_start_in = 1'b0, desc_ready_in = 1'b0, f;
  logic [1:0]  desc_sel_in = 2'h0;
  logic [15:0] desc_char_out, language_code_out;
  logic        desc_valid_out, desc_last_out, desc_busy_out;
  logic [8:0]  controller_current_ma_out;
  logic [7:0]  port_power_good_delay_out;
  logic [3:0]  port_power_start_in = 4'h0, port_power_stop_in = 4'h0;
  logic [3:0]  port_power_good_out;
  int          n_fail = 0, n_tests = 0;
  always #10 sys_clk_in = ~sys_clk_in;
  // Short unit keeps the power timer runs brief
  hcd_cfg_regs #(.PORTS(4), .UNIT_CYCLES(3)) dut (.sys_clk_in,
    .sys_rst_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in,
    .cfg_rdata_out, .cfg_rvalid_out, .cfg_wr_refused_out, .desc_start_in,
    .desc_sel_in, .desc_ready_in, .desc_char_out, .desc_valid_out,
    .desc_last_out, .desc_busy_out, .language_code_out,
    .controller_current_ma_out, .port_power_good_delay_out,
    .port_power_start_in, .port_power_stop_in, .port_power_good_out);
  hcd_loader_model ld (.sys_clk_in, .rdata_in(cfg_rdata_out),
    .rvalid_in(cfg_rvalid_out), .refused_in(cfg_wr_refused_out),
    .wr_out(cfg_wr_in), .rd_out(cfg_rd_in), .addr_out(cfg_addr_in),
    .wdata_out(cfg_wdata_in));
  task automatic chk(input string n, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    ld.xfer(1'b1, a, d, q, f);
  endtask
  task automatic rd(input logic [7:0] a);
    ld.xfer(1'b0, a, 8'h00, q, f);
  endtask
  function automatic logic [15:0] ch(input int s, n);
    return {8'(s * 64 + n + 1), 8'(n ^ 8'h5a)};
  endfunction
  task automatic t_reset;
    sys_rst_in = 1'b1;
    tick(10);
    sys_rst_in = 1'b0;
    rd(hcd_pkg::ADDR_CUR_BP);
    chk("cur reg", 16'(q), 16'h0032);
    chk("rd valid", 16'(f), 16'h0001);
    chk("cur ma", 16'(controller_current_ma_out), 16'h0064);
  endtask
  task automatic t_regs;
    wr(hcd_pkg::ADDR_CUR_BP, 8'hff);
    tick(1);
    chk("cur ma", 16'(controller_current_ma_out), 16'h01fe);
    wr(hcd_pkg::ADDR_LANG_HI, 8'h04);
    wr(hcd_pkg::ADDR_LANG_LO, 8'h09);
    tick(1);
    chk("lang", language_code_out, 16'h0409);
  endtask
  task automatic t_len;
    wr(hcd_pkg::ADDR_MFR_LEN, 8'h1f);
    chk("len ok", 16'(f), 16'h0000);
    wr(hcd_pkg::ADDR_MFR_LEN, 8'h20);
    chk("len refused", 16'(f), 16'h0001);
    rd(hcd_pkg::ADDR_MFR_LEN);
    chk("len kept", 16'(q), 16'h001f);
    wr(8'hd0, 8'haa);
    chk("unmapped wr", 16'(f), 16'h0001);
    rd(8'hd0);
    chk("unmapped rd", 16'(q), 16'h0000);
  endtask
  // One spare character past the length, written for lengths below 31, must never be sent
  task automatic t_str(input int s, len);
    logic [7:0] b;
    int k;
    b = 8'(hcd_pkg::ADDR_MFR_TEXT + s * hcd_pkg::AREA_BYTES);
    for (int n = 0; n <= len && n < 31; n++) begin
      wr(8'(b + 2 * n), 8'(ch(s, n) & 16'h00ff));
      wr(8'(b + 2 * n + 1), 8'(ch(s, n) >> 8));
    end
    // Stored bytes read back as written, low byte first
    rd(b);
    chk("text lo", 16'(q), ch(s, 0) & 16'h00ff);
    rd(8'(b + 1));
    chk("text hi", 16'(q), ch(s, 0) >> 8);
    wr(8'(hcd_pkg::ADDR_MFR_LEN + s), 8'(len));
    desc_sel_in = 2'(s);
    desc_start_in = 1'b1;
    tick(1);
    desc_start_in = 1'b0;
    k = 0;
    for (int i = 0; i < 200 && k < len; i++) begin
      tick(1);
      desc_ready_in = i[0];
      if (desc_valid_out === 1'b1 && desc_ready_in) begin
        chk("char", desc_char_out, ch(s, k));
        chk("last", 16'(desc_last_out), 16'(k == len - 1));
        k++;
      end
    end
    tick(3);
    chk("count", 16'(k), 16'(len));
    chk("idle", 16'({desc_valid_out, desc_busy_out}), 16'h0000);
  endtask
  task automatic t_pwr(input int p, input logic [7:0] d);
    int n;
    wr(hcd_pkg::ADDR_PWR_DLY, d);
    chk("pwr dly out", 16'(port_power_good_delay_out), 16'(d));
    port_power_start_in[p] = 1'b1;
    tick(1);
    port_power_start_in[p] = 1'b0;
    n = 0;
    while (port_power_good_out[p] !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    // Zero units: good already stands at the start edge
    chk("pwr delay", 16'(n), 16'(d * 3));
    port_power_stop_in[p] = 1'b1;
    tick(1);
    port_power_stop_in[p] = 1'b0;
    tick(1);
    chk("pwr off", 16'(port_power_good_out), 16'h0000);
  endtask
  task automatic stop_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_regs();
    t_len();
    t_str(0, 2);
    t_str(1, 31);
    t_str(2, 1);
    t_pwr(0, 8'h02);
    t_pwr(3, 8'h00);
    t_reset();
    stop_test();
  end
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end
endmodule
